// ---- src/ipm_pkg.sv ----
// Constants, types and register map for the indicator pin mux block
package ipm_pkg;

	// Management device address and register addresses
	localparam logic [4:0] IPM_DEVAD = 5'h1e;
	localparam logic [15:0] IPM_PINMUX1_ADDR = 16'h8c56;
	localparam logic [15:0] IPM_PINMUX2_ADDR = 16'h8c57;
	localparam logic [15:0] IPM_BLINK0_ADDR = 16'h8c80;

	// Reset values
	localparam logic [15:0] IPM_PINMUX1_RST = 16'h00fe;
	localparam logic [15:0] IPM_PINMUX2_RST = 16'h00ff;
	localparam logic [15:0] IPM_BLINK0_RST = 16'h3636;

	// Reserved bits of the first pin mux register read back as ones here
	localparam logic [15:0] IPM_PINMUX1_RSVD = 16'h00f0;

	// Field positions
	localparam int IPM_LED1SEL_MSB = 3;
	localparam int IPM_LED1SEL_LSB = 1;
	localparam int IPM_LINKPOL_BIT = 0;
	localparam int IPM_RXSOP_MSB = 7;
	localparam int IPM_RXSOP_LSB = 4;
	localparam int IPM_TXSOP_MSB = 3;
	localparam int IPM_TXSOP_LSB = 0;
	localparam int IPM_ON_MSB = 15;
	localparam int IPM_ON_LSB = 8;
	localparam int IPM_OFF_MSB = 7;
	localparam int IPM_OFF_LSB = 0;

	// Indicator 1 select codes
	localparam logic [2:0] IPM_LED1SEL_ON = 3'h0;
	localparam logic [2:0] IPM_LED1SEL_OFF = 3'h7;

	// Packet-start pin codes
	localparam int IPM_MAC_PINS = 12;
	localparam int IPM_SOP_PINS = 15;
	localparam logic [3:0] IPM_SOP_LINK = 4'hc;
	localparam logic [3:0] IPM_SOP_LED0 = 4'hd;
	localparam logic [3:0] IPM_SOP_LED1 = 4'he;
	localparam logic [3:0] IPM_SOP_OFF = 4'hf;

	// Timebase: 4 ms tick from a 125 MHz clock
	localparam int IPM_TICK_MS = 4;
	localparam int IPM_CLK_KHZ = 125000;
	localparam int IPM_TICK_CYCLES = IPM_TICK_MS * IPM_CLK_KHZ;
	localparam int IPM_PRE_W = 20;

	// Indicator source selection
	typedef enum logic [2:0] {
		IPM_SRC_OFF = 3'h0,
		IPM_SRC_ON = 3'h1,
		IPM_SRC_BLINK = 3'h2,
		IPM_SRC_LINK_ACT = 3'h3,
		IPM_SRC_ACT = 3'h4
	} ipm_source_t;

	// Blink phase states
	typedef enum logic [1:0] {
		IPM_PH_IDLE,
		IPM_PH_OFF,
		IPM_PH_ON
	} ipm_phase_t;

	// Blink timing fields
	typedef struct packed {
		logic [7:0] onTicks;
		logic [7:0] offTicks;
	} ipm_blink_cfg_t;

	// Register access request
	typedef struct packed {
		logic [4:0] devAddr;
		logic [15:0] regAddr;
		logic write;
		logic read;
		logic [15:0] wdata;
	} ipm_reg_req_t;

endpackage

// ---- src/ipm_blink_timer.sv ----
// Blink phase timer for indicator 0
`timescale 1ns/1ns
module ipm_blink_timer
	import ipm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = IPM_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic startOn,
	input wire logic restart,
	input wire ipm_blink_cfg_t cfg,
	output logic blinkOn
);

	localparam logic [IPM_PRE_W-1:0] PRE_LAST =
		IPM_PRE_W'(TICK_CYCLES - 1);

	ipm_phase_t phase; // Current phase
	ipm_phase_t next_phase;
	logic [7:0] cnt; // Ticks left in phase
	logic [7:0] next_cnt;
	logic [IPM_PRE_W-1:0] pre; // Cycles within a tick
	logic [IPM_PRE_W-1:0] next_pre;
	logic next_blinkOn;
	logic tick;

	assign tick = (pre == PRE_LAST);

	// Phase sequencing; prescaler restarts with each phase
	always_comb begin
		next_phase = phase;
		next_cnt = cnt;
		next_pre = pre;
		next_blinkOn = blinkOn;
		if (!run || restart) begin
			next_phase = IPM_PH_IDLE;
			next_pre = '0;
			next_cnt = '0;
			next_blinkOn = 1'b0;
		end else begin
			case (phase)
				IPM_PH_IDLE: begin
					next_pre = '0;
					if (startOn) begin
						next_phase = IPM_PH_ON;
						next_cnt = cfg.onTicks;
						next_blinkOn = 1'b1;
					end else begin
						next_phase = IPM_PH_OFF;
						next_cnt = cfg.offTicks;
						next_blinkOn = 1'b0;
					end
				end
				IPM_PH_OFF: begin
					if (cnt == 8'h00) begin
						next_phase = IPM_PH_ON;
						next_cnt = cfg.onTicks;
						next_pre = '0;
						next_blinkOn = 1'b1;
					end else if (tick) begin
						next_pre = '0;
						next_cnt = cnt - 8'h01;
					end else begin
						next_pre = pre + 1'b1;
					end
				end
				IPM_PH_ON: begin
					if (cnt == 8'h00) begin
						next_phase = IPM_PH_OFF;
						next_cnt = cfg.offTicks;
						next_pre = '0;
						next_blinkOn = 1'b0;
					end else if (tick) begin
						next_pre = '0;
						next_cnt = cnt - 8'h01;
					end else begin
						next_pre = pre + 1'b1;
					end
				end
				default: begin
					next_phase = IPM_PH_IDLE;
					next_blinkOn = 1'b0;
				end
			endcase
		end
	end

	// Phase registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			phase <= IPM_PH_IDLE;
			cnt <= '0;
			pre <= '0;
			blinkOn <= 1'b0;
		end else begin
			phase <= next_phase;
			cnt <= next_cnt;
			pre <= next_pre;
			blinkOn <= next_blinkOn;
		end
	end

endmodule

// ---- src/ipm_indicator_mux.sv ----
// Indicator pin mux, link pin polarity, packet-start routing, LED0 blink
`timescale 1ns/1ns
module ipm_indicator_mux
	import ipm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = IPM_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	// Register access from the management block
	input wire ipm_reg_req_t regReq,
	output logic [15:0] regRdata,
	output logic regAck,
	// Indicator 0 controls held outside this block
	input wire logic indicator0Enable,
	input wire logic indicatorBlinkOrder,
	input wire ipm_source_t indicatorSourceSelect,
	// Indicator 1 level and enable from its own controller
	input wire logic indicator1Enable,
	input wire logic indicator1Level,
	// PHY core status, same clock domain
	input wire logic linkUp,
	input wire logic rxActivity,
	input wire logic rxPacketStart,
	input wire logic txPacketStart,
	// Pins
	output logic indicatorPin0,
	output logic indicatorPin1,
	output logic indicatorPin1Oe,
	output logic linkStatusPin,
	output logic [IPM_MAC_PINS-1:0] sopPinEnable,
	output logic [IPM_MAC_PINS-1:0] sopPinLevel
);

	// Configuration fields
	logic [2:0] indicator1PinSelect;
	logic [2:0] next_indicator1PinSelect;
	logic linkPinPolarity;
	logic next_linkPinPolarity;
	logic [3:0] rxPacketStartPinSelect;
	logic [3:0] next_rxPacketStartPinSelect;
	logic [3:0] txPacketStartPinSelect;
	logic [3:0] next_txPacketStartPinSelect;
	ipm_blink_cfg_t blinkCfg;
	ipm_blink_cfg_t next_blinkCfg;

	// Read answer
	logic [15:0] next_regRdata;
	logic next_regAck;

	// Decoded accesses
	logic devHit;
	logic hitMux1;
	logic hitMux2;
	logic hitBlink;
	logic blinkWrite;

	// Indicator 0 path
	logic liveMode;
	logic blinkRun;
	logic blinkOn;
	logic next_indicatorPin0;

	// Pin outputs
	logic next_indicatorPin1;
	logic next_indicatorPin1Oe;
	logic next_linkStatusPin;
	logic [IPM_SOP_PINS-1:0] sopEnAll;
	logic [IPM_SOP_PINS-1:0] sopLvAll;

	assign devHit = (regReq.devAddr == IPM_DEVAD);
	assign hitMux1 = devHit && (regReq.regAddr == IPM_PINMUX1_ADDR);
	assign hitMux2 = devHit && (regReq.regAddr == IPM_PINMUX2_ADDR);
	assign hitBlink = devHit && (regReq.regAddr == IPM_BLINK0_ADDR);
	assign blinkWrite = hitBlink && regReq.write;

	// Register writes; reserved bits are not stored
	always_comb begin
		next_indicator1PinSelect = indicator1PinSelect;
		next_linkPinPolarity = linkPinPolarity;
		next_rxPacketStartPinSelect = rxPacketStartPinSelect;
		next_txPacketStartPinSelect = txPacketStartPinSelect;
		next_blinkCfg = blinkCfg;
		if (regReq.write) begin
			if (hitMux1) begin
				next_indicator1PinSelect =
					regReq.wdata[IPM_LED1SEL_MSB:IPM_LED1SEL_LSB];
				next_linkPinPolarity = regReq.wdata[IPM_LINKPOL_BIT];
			end
			if (hitMux2) begin
				next_rxPacketStartPinSelect =
					regReq.wdata[IPM_RXSOP_MSB:IPM_RXSOP_LSB];
				next_txPacketStartPinSelect =
					regReq.wdata[IPM_TXSOP_MSB:IPM_TXSOP_LSB];
			end
			if (hitBlink) begin
				next_blinkCfg.onTicks =
					regReq.wdata[IPM_ON_MSB:IPM_ON_LSB];
				next_blinkCfg.offTicks =
					regReq.wdata[IPM_OFF_MSB:IPM_OFF_LSB];
			end
		end
	end

	// Read data; unmapped addresses answer zero
	always_comb begin
		next_regAck = regReq.read || regReq.write;
		next_regRdata = 16'h0000;
		if (regReq.read) begin
			if (hitMux1) begin
				next_regRdata = IPM_PINMUX1_RSVD;
				next_regRdata[IPM_LED1SEL_MSB:IPM_LED1SEL_LSB] =
					indicator1PinSelect;
				next_regRdata[IPM_LINKPOL_BIT] = linkPinPolarity;
			end else if (hitMux2) begin
				next_regRdata[IPM_RXSOP_MSB:IPM_RXSOP_LSB] =
					rxPacketStartPinSelect;
				next_regRdata[IPM_TXSOP_MSB:IPM_TXSOP_LSB] =
					txPacketStartPinSelect;
			end else if (hitBlink) begin
				next_regRdata[IPM_ON_MSB:IPM_ON_LSB] = blinkCfg.onTicks;
				next_regRdata[IPM_OFF_MSB:IPM_OFF_LSB] = blinkCfg.offTicks;
			end
		end
	end

	// Register file
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			indicator1PinSelect <=
				IPM_PINMUX1_RST[IPM_LED1SEL_MSB:IPM_LED1SEL_LSB];
			linkPinPolarity <= IPM_PINMUX1_RST[IPM_LINKPOL_BIT];
			rxPacketStartPinSelect <=
				IPM_PINMUX2_RST[IPM_RXSOP_MSB:IPM_RXSOP_LSB];
			txPacketStartPinSelect <=
				IPM_PINMUX2_RST[IPM_TXSOP_MSB:IPM_TXSOP_LSB];
			blinkCfg.onTicks <= IPM_BLINK0_RST[IPM_ON_MSB:IPM_ON_LSB];
			blinkCfg.offTicks <= IPM_BLINK0_RST[IPM_OFF_MSB:IPM_OFF_LSB];
			regRdata <= 16'h0000;
			regAck <= 1'b0;
		end else begin
			indicator1PinSelect <= next_indicator1PinSelect;
			linkPinPolarity <= next_linkPinPolarity;
			rxPacketStartPinSelect <= next_rxPacketStartPinSelect;
			txPacketStartPinSelect <= next_txPacketStartPinSelect;
			blinkCfg <= next_blinkCfg;
			regRdata <= next_regRdata;
			regAck <= next_regAck;
		end
	end

	// Both times zero turns the timer off and shows the source live
	assign liveMode = (blinkCfg.onTicks == 8'h00) &&
		(blinkCfg.offTicks == 8'h00);

	// Timer runs only while the selected source calls for blinking
	always_comb begin
		blinkRun = 1'b0;
		if (indicator0Enable && !liveMode) begin
			case (indicatorSourceSelect)
				IPM_SRC_BLINK: blinkRun = 1'b1;
				IPM_SRC_ACT: blinkRun = rxActivity;
				IPM_SRC_LINK_ACT: blinkRun = linkUp && rxActivity;
				default: blinkRun = 1'b0;
			endcase
		end
	end

	// Blink timer; a timing write restarts the phase
	ipm_blink_timer #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_blink (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.run(blinkRun),
		.startOn(indicatorBlinkOrder),
		.restart(blinkWrite),
		.cfg(blinkCfg),
		.blinkOn(blinkOn)
	);

	// Indicator 0 level from source, activity and blink phase
	always_comb begin
		next_indicatorPin0 = 1'b0;
		if (!indicator0Enable) begin
			next_indicatorPin0 = 1'b0;
		end else begin
			case (indicatorSourceSelect)
				IPM_SRC_ON: next_indicatorPin0 = 1'b1;
				IPM_SRC_BLINK: next_indicatorPin0 = liveMode || blinkOn;
				IPM_SRC_LINK_ACT: begin
					if (!linkUp) begin
						next_indicatorPin0 = 1'b0;
					end else if (rxActivity) begin
						next_indicatorPin0 = !liveMode && blinkOn;
					end else begin
						next_indicatorPin0 = 1'b1;
					end
				end
				IPM_SRC_ACT: begin
					if (rxActivity) begin
						next_indicatorPin0 = liveMode || blinkOn;
					end else begin
						next_indicatorPin0 = 1'b0;
					end
				end
				default: next_indicatorPin0 = 1'b0;
			endcase
		end
	end

	// Packet-start routing; each pin compares both selects with its code
	genvar gi;
	generate
		for (gi = 0; gi < IPM_SOP_PINS; gi++) begin : g_sop
			logic rxHit;
			logic txHit;
			assign rxHit = (rxPacketStartPinSelect == 4'(gi));
			assign txHit = (txPacketStartPinSelect == 4'(gi));
			assign sopEnAll[gi] = rxHit || txHit;
			assign sopLvAll[gi] = (rxHit && rxPacketStart) ||
				(txHit && txPacketStart);
		end
	endgenerate

	// Indicator 1, link pin; a routed marker takes the pin over
	always_comb begin
		next_indicatorPin1 = 1'b0;
		next_indicatorPin1Oe = 1'b0;
		if (sopEnAll[IPM_SOP_LED1]) begin
			next_indicatorPin1 = sopLvAll[IPM_SOP_LED1];
			next_indicatorPin1Oe = 1'b1;
		end else if (indicator1PinSelect == IPM_LED1SEL_ON) begin
			next_indicatorPin1 = indicator1Enable && indicator1Level;
			next_indicatorPin1Oe = 1'b1;
		end
		if (sopEnAll[IPM_SOP_LINK]) begin
			next_linkStatusPin = sopLvAll[IPM_SOP_LINK];
		end else begin
			next_linkStatusPin = linkUp ^ linkPinPolarity;
		end
	end

	// Pin registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			indicatorPin0 <= 1'b0;
			indicatorPin1 <= 1'b0;
			indicatorPin1Oe <= 1'b0;
			linkStatusPin <= 1'b0;
			sopPinEnable <= '0;
			sopPinLevel <= '0;
		end else begin
			if (sopEnAll[IPM_SOP_LED0]) begin
				indicatorPin0 <= sopLvAll[IPM_SOP_LED0];
			end else begin
				indicatorPin0 <= next_indicatorPin0;
			end
			indicatorPin1 <= next_indicatorPin1;
			indicatorPin1Oe <= next_indicatorPin1Oe;
			linkStatusPin <= next_linkStatusPin;
			sopPinEnable <= sopEnAll[IPM_MAC_PINS-1:0];
			sopPinLevel <= sopLvAll[IPM_MAC_PINS-1:0];
		end
	end

endmodule

// ---- tb/ipm_pin_load.sv ----
// Far-side load on the shared indicator 1 pin
`timescale 1ns/1ns
module ipm_pin_load (
	input wire logic indicatorPin1,
	input wire logic indicatorPin1Oe,
	output logic pin1Wire
);
	// The line has a pull-down, so a released pin reads low
	assign pin1Wire = indicatorPin1Oe ? indicatorPin1 : 1'b0;
endmodule

// ---- tb/ipm_indicator_mux_checker.sv ----
// Port assertions for the indicator pin mux block
`timescale 1ns/1ns
module ipm_indicator_mux_checker
	import ipm_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = IPM_TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire ipm_reg_req_t regReq,
	input wire logic [15:0] regRdata,
	input wire logic regAck,
	input wire logic indicator0Enable,
	input wire ipm_source_t indicatorSourceSelect,
	input wire logic indicator1Enable,
	input wire logic linkUp,
	input wire logic rxPacketStart,
	input wire logic txPacketStart,
	input wire logic indicatorPin0,
	input wire logic indicatorPin1,
	input wire logic indicatorPin1Oe,
	input wire logic linkStatusPin,
	input wire logic [IPM_MAC_PINS-1:0] sopPinEnable,
	input wire logic [IPM_MAC_PINS-1:0] sopPinLevel
);
	logic [3:0] pm1; // Shadow of the first select register
	logic [7:0] pm2; // Shadow of the marker selects
	logic [3:0] pm1q; // Shadow as the registered pins last used it
	logic [7:0] pm2q; // Marker selects as the pins last used them
	logic hit; // Write aimed at this device
	assign hit = regReq.write && regReq.devAddr == IPM_DEVAD;
	// Track writable fields; the q copies match the one-cycle pin lag
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pm1 <= IPM_PINMUX1_RST[3:0];
			pm2 <= IPM_PINMUX2_RST[7:0];
			pm1q <= IPM_PINMUX1_RST[3:0];
			pm2q <= IPM_PINMUX2_RST[7:0];
		end else begin
			pm1q <= pm1;
			pm2q <= pm2;
			if (hit && regReq.regAddr == IPM_PINMUX1_ADDR) begin
				pm1 <= regReq.wdata[3:0];
			end else if (hit && regReq.regAddr == IPM_PINMUX2_ADDR) begin
				pm2 <= regReq.wdata[7:0];
			end
		end
	end
	// One-hot pin decode of a marker select
	function automatic logic [11:0] dec(input logic [3:0] c);
		return (c < 4'hc) ? 12'h001 << c : 12'h000;
	endfunction
	// Either marker routed to the given code
	function automatic logic rt(input logic [7:0] s, input logic [3:0] c);
		return s[7:4] == c || s[3:0] == c;
	endfunction
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_req;
		regReq.read || regReq.write;
	endsequence
	sequence s_off0;
		!indicator0Enable [*2];
	endsequence
	sequence s_on0;
		(indicator0Enable && indicatorSourceSelect == IPM_SRC_ON) [*2];
	endsequence
	sequence s_off1;
		!indicator1Enable [*2];
	endsequence
	a_ack_after_req: assert property (s_req |=> regAck)
		else $error("no ack after request");
	a_ack_needs_req: assert property (regAck |->
		$past(regReq.read) || $past(regReq.write))
		else $error("ack without request");
	a_rdata_idle_zero: assert property (
		!regAck |-> regRdata == 16'h0000)
		else $error("read data outside ack");
	a_marker_sel_read: assert property (regReq.read &&
		hit == 1'b0 && regReq.devAddr == IPM_DEVAD &&
		regReq.regAddr == IPM_PINMUX2_ADDR
		|=> regRdata == {8'h00, pm2})
		else $error("marker select read wrong");
	a_link_pin_pol: assert property ($past(nrst) &&
		!rt(pm2q, IPM_SOP_LINK) |->
		linkStatusPin == ($past(linkUp) ^ pm1q[0]))
		else $error("link pin polarity wrong");
	a_ind1_oe_sel: assert property ($past(nrst) |->
		indicatorPin1Oe ==
		(pm1q[3:1] == IPM_LED1SEL_ON || rt(pm2q, IPM_SOP_LED1)))
		else $error("indicator 1 enable wrong");
	a_marker_pin_en: assert property ($past(nrst) |->
		sopPinEnable == (dec(pm2q[7:4]) | dec(pm2q[3:0])))
		else $error("marker pin enable wrong");
	a_marker_pin_lvl: assert property ($past(nrst) |->
		(sopPinLevel & sopPinEnable) ==
		((dec(pm2q[7:4]) & {12{$past(rxPacketStart)}}) |
		(dec(pm2q[3:0]) & {12{$past(txPacketStart)}})))
		else $error("marker pin level wrong");
	a_ind0_forced_off: assert property (s_off0 ##0
		!rt(pm2, IPM_SOP_LED0) |=> !indicatorPin0)
		else $error("disabled indicator 0 lit");
	a_ind0_steady_on: assert property (s_on0 ##0
		!rt(pm2, IPM_SOP_LED0) |=> indicatorPin0)
		else $error("enabled indicator 0 not lit");
	a_ind1_forced_off: assert property (s_off1 ##0
		!rt(pm2, IPM_SOP_LED1) |=> !indicatorPin1)
		else $error("disabled indicator 1 lit");
endmodule

// ---- tb/ipm_indicator_mux_tb.sv ----
// Self-checking bench for the indicator pin mux block
`timescale 1ns/1ns
module ipm_indicator_mux_tb;
	import ipm_pkg::*;
	localparam int TK = 4; // Short tick for simulation
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	ipm_reg_req_t regReq = '0;
	logic [15:0] regRdata;
	logic regAck;
	logic en0 = 1'b0;
	logic ord = 1'b0;
	ipm_source_t src = IPM_SRC_OFF;
	logic en1 = 1'b0;
	logic lvl1 = 1'b0;
	logic lnk = 1'b0;
	logic act = 1'b0;
	logic rxS = 1'b0;
	logic txS = 1'b0;
	logic p0, p1, p1Oe, lnkPin, wire1;
	logic [11:0] sopEn, sopLv;
	int failures = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h00010591; // Fixed seed for repeatable runs
	always #4 sys_clk = ~sys_clk;
	ipm_indicator_mux #(.TICK_CYCLES(TK)) dut (.sys_clk(sys_clk),
		.nrst(nrst), .regReq(regReq), .regRdata(regRdata),
		.regAck(regAck), .indicator0Enable(en0),
		.indicatorBlinkOrder(ord), .indicatorSourceSelect(src),
		.indicator1Enable(en1), .indicator1Level(lvl1), .linkUp(lnk),
		.rxActivity(act), .rxPacketStart(rxS), .txPacketStart(txS),
		.indicatorPin0(p0), .indicatorPin1(p1), .indicatorPin1Oe(p1Oe),
		.linkStatusPin(lnkPin), .sopPinEnable(sopEn), .sopPinLevel(sopLv));
	ipm_pin_load load (.indicatorPin1(p1), .indicatorPin1Oe(p1Oe),
		.pin1Wire(wire1));
	// Xorshift source for random stimulus
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected one-hot pin for a marker select
	function automatic logic [15:0] dec(input logic [3:0] c);
		return (c < 4'hc) ? 16'h0001 << c : 16'h0000;
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// One register access; answer is sampled in the ack cycle
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [15:0] d, output logic [15:0] q);
		wt(1);
		regReq.write = w;
		regReq.read = !w;
		regReq.regAddr = a;
		regReq.wdata = d;
		wt(1);
		regReq.write = 1'b0;
		regReq.read = 1'b0;
		q = regRdata;
		chk(16'(regAck), 16'h0001);
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] q;
		acc(1'b0, a, 16'h0000, q);
		chk(q, e);
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] q;
		acc(1'b1, a, d, q);
	endtask
	// Cycles until indicator 0 changes level
	task automatic runLen(output int n);
		logic v;
		v = p0;
		n = 0;
		while (p0 === v && n < 2000) begin
			wt(1);
			n++;
		end
	endtask
	task automatic close_out();
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Cut a hang short
	initial begin
		#400000;
		failures++;
		close_out();
	end
	initial begin
		int n;
		logic [15:0] w;
		regReq.devAddr = IPM_DEVAD;
		wt(4);
		nrst = 1'b1;
		// Reset values, unmapped place, foreign device address
		rd(IPM_PINMUX1_ADDR, IPM_PINMUX1_RST);
		rd(IPM_PINMUX2_ADDR, IPM_PINMUX2_RST);
		rd(IPM_BLINK0_ADDR, IPM_BLINK0_RST);
		rd(16'h8c58, 16'h0000);
		regReq.devAddr = 5'h01;
		wr(IPM_PINMUX1_ADDR, 16'h0001);
		rd(IPM_PINMUX1_ADDR, 16'h0000);
		regReq.devAddr = IPM_DEVAD;
		rd(IPM_PINMUX1_ADDR, IPM_PINMUX1_RST);
		// Random selects, polarity and indicator 1 levels
		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? 16'h00c0 : 16'(rnd());
			lnk = w[5];
			en1 = w[6];
			lvl1 = w[7];
			wr(IPM_PINMUX1_ADDR, w);
			rd(IPM_PINMUX1_ADDR, (w & 16'h000f) | IPM_PINMUX1_RSVD);
			// Software keeps both times above 3
			wr(IPM_BLINK0_ADDR, w | 16'h0404);
			rd(IPM_BLINK0_ADDR, w | 16'h0404);
			chk(16'(lnkPin), 16'(lnk ^ w[0]));
			chk(16'(wire1), 16'(w[3:1] == 3'h0 && w[6] && w[7]));
		end
		// Every marker code, receive and transmit on opposite codes
		rxS = 1'b1;
		for (int c = 0; c < 16; c++) begin
			wr(IPM_PINMUX2_ADDR, 16'(c * 16 + 15 - c));
			wt(1);
			chk(16'(sopEn), dec(4'(c)) | dec(4'(15 - c)));
			chk(16'(sopLv & sopEn), dec(4'(c)));
			// Link and indicator pins carry the marker when routed there
			if (c == 12 || c == 3) begin
				chk(16'(lnkPin), 16'(c == 12));
			end
			if (c == 13 || c == 2) begin
				chk(16'(p0), 16'(c == 13));
			end
			if (c == 14 || c == 1) begin
				chk(16'(wire1), 16'(c == 14));
			end
		end
		rxS = 1'b0;
		wr(IPM_PINMUX2_ADDR, IPM_PINMUX2_RST);
		// Blink order and phase lengths in ticks
		en0 = 1'b1;
		wr(IPM_BLINK0_ADDR, 16'h0405);
		for (int o = 0; o < 2; o++) begin
			src = o ? IPM_SRC_OFF : IPM_SRC_ON;
			ord = 1'(o);
			wt(3);
			src = IPM_SRC_BLINK;
			runLen(n);
			chk(16'(p0), 16'(o));
			chk(16'(n <= 4), 16'h0001);
			runLen(n);
			// Order 0 goes dark on the same edge its off phase begins, not one edge after it
			chk(16'(n), 16'(o ? 4 * TK + 1 : 5 * TK + 2));
			runLen(n);
			chk(16'(n), 16'((o ? 5 : 4) * TK + 1));
		end
		// Activity blinks at the programmed rate, idle stays dark
		src = IPM_SRC_ACT;
		ord = 1'b0;
		act = 1'b1;
		runLen(n);
		w = p0 ? 16'(4 * TK + 1) : 16'(5 * TK + 1);
		runLen(n);
		chk(16'(n), w);
		act = 1'b0;
		wt(4);
		chk(16'(p0), 16'h0000);
		en0 = 1'b0;
		wt(3);
		chk(16'(p0), 16'h0000);
		en0 = 1'b1;
		// Both times zero: sources follow activity live
		wr(IPM_BLINK0_ADDR, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			w = 16'(rnd());
			act = w[0];
			lnk = w[1];
			src = IPM_SRC_ACT;
			wt(3);
			chk(16'(p0), 16'(act));
			src = IPM_SRC_LINK_ACT;
			wt(3);
			chk(16'(p0), 16'(lnk && !act));
		end
		close_out();
	end
endmodule
bind ipm_indicator_mux ipm_indicator_mux_checker #(
	.TICK_CYCLES(TICK_CYCLES)) u_chk (.sys_clk(sys_clk), .nrst(nrst),
	.regReq(regReq), .regRdata(regRdata), .regAck(regAck),
	.indicator0Enable(indicator0Enable),
	.indicatorSourceSelect(indicatorSourceSelect),
	.indicator1Enable(indicator1Enable), .linkUp(linkUp),
	.rxPacketStart(rxPacketStart), .txPacketStart(txPacketStart),
	.indicatorPin0(indicatorPin0), .indicatorPin1(indicatorPin1),
	.indicatorPin1Oe(indicatorPin1Oe), .linkStatusPin(linkStatusPin),
	.sopPinEnable(sopPinEnable), .sopPinLevel(sopPinLevel));
